/* verification/dpp_link_monitor.sv */
// concurrent checks on the image link
`timescale 1ns/1ps
`default_nettype none

module dpp_link_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link signals
	input wire logic o2dValid,
	input wire logic [7:0] o2dData,
	input wire logic o2dLast,
	input wire logic d2hValid,
	input wire logic [7:0] d2hData,
	input wire logic d2hLast,
	input wire logic d2hKind
);
	logic diagOn;
	logic [4:0] idx_q;
	logic [4:0] idx_d;
	logic [2:0] oIdx_q;
	logic [2:0] oIdx_d;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// byte position in the diagnostic frame, zero outside it
	assign diagOn = d2hValid && d2hKind;
	assign idx_d = (diagOn && !d2hLast) ? idx_q + 5'h01 : 5'h00;
	// output image byte position, held at 4 once past the header
	assign oIdx_d = (o2dValid && o2dLast) ? 3'h0 :
		(o2dValid && oIdx_q != 3'h4) ? oIdx_q + 3'h1 : oIdx_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			idx_q <= 5'h00;
			oIdx_q <= 3'h0;
		end else begin
			idx_q <= idx_d;
			oIdx_q <= oIdx_d;
		end
	end

	property p_diag_len;
		diagOn && d2hLast |-> idx_q == 5'h11;
	endproperty
	a_diag_len: assert property (p_diag_len) else $error("diag frame length");
	property p_diag_next;
		d2hValid && !d2hKind && d2hLast |=> diagOn && idx_q == 5'h00;
	endproperty
	a_diag_next: assert property (p_diag_next) else $error("diag not after image");
	property p_diag_solid;
		diagOn && !d2hLast |=> diagOn;
	endproperty
	a_diag_solid: assert property (p_diag_solid) else $error("diag frame broken");
	property p_frame_end;
		diagOn && d2hLast |=> !d2hValid;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("valid after frame");
	property p_out_zero;
		diagOn && idx_q inside {5'h0A, 5'h0C, 5'h0E} |-> d2hData == 8'h00;
	endproperty
	a_out_zero: assert property (p_out_zero) else $error("low output diag byte set");
	property p_out_upper;
		diagOn && idx_q inside {5'h0B, 5'h0D, 5'h0F} |-> d2hData[7:4] == 4'h0;
	endproperty
	a_out_upper: assert property (p_out_upper) else $error("channel 13-16 flag set");
	property p_class;
		diagOn && idx_q == 5'h10 |-> !(d2hData[5] && d2hData[4]) && !d2hData[6];
	endproperty
	a_class: assert property (p_class) else $error("warning and alarm together");
	property p_ext_byte;
		diagOn && idx_q == 5'h11 |-> d2hData[6:0] == 7'h00;
	endproperty
	a_ext_byte: assert property (p_ext_byte) else $error("reserved status bits set");
	property p_out_rsvd;
		o2dValid && (oIdx_q == 3'h2 || oIdx_q == 3'h3) |-> o2dData == 8'h00;
	endproperty
	a_out_rsvd: assert property (p_out_rsvd) else $error("reserved output word set");
endmodule

`default_nettype wire

/* verification/tb_diag_and_process_image_packer.sv */
// self-checking bench for the image packer, both ends joined
`timescale 1ns/1ps
`default_nettype none

module tb_diag_and_process_image_packer
	import dpp_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cycleReq = 1'b0;
	logic txStart = 1'b0;
	logic isInputOnly = 1'b0;
	logic busy, txBusy, sinkValid, outLenErr, rxValid, rxKind, rxLenErr;
	dpp_map_t pmap = {{16{6'h20}}, {8{2'h2}}};
	logic [15:0] dinStatus = 16'h3CA5;
	logic [15:0] genDiag = 16'hC3B2;
	logic [15:0] sensorDiag = 16'h1E2D;
	logic [15:0] actDiag = 16'h7F60;
	logic [47:0] iolDiag = 48'h0A0908070605;
	logic [63:0] dinDiag = 64'h8877665544332211;
	logic [15:0] doutCtrl = 16'h0F00;
	logic [4:0] devFlags = 5'h00;
	dpp_xstat_t extStatus = DPP_XS_NONE;
	logic [3:0] shortGnd = 4'h0, shortNoGnd = 4'h0, overload = 4'h0, outDrive, outLedRed;
	logic [3:0] expRb = 4'h0, expTp = 4'h0, expOv = 4'h0;
	dpp_field_t srcField, rxField;
	logic [2:0] srcPort, sinkPort, txPort, rxPort;
	logic [5:0] srcIndex, sinkIndex, txIndex, rxIndex;
	logic [7:0] srcByte, sinkByte, txByte, rxByte;
	logic [7:0] expImg[$], img[$], dg[$], rxImg[$];
	logic [7:0] codes[12] = '{8'h00, 8'h05, 8'h06, 8'h0F, 8'h12, 8'h41, 8'h42, 8'h4B,
		8'h4C, 8'h4D, 8'h4E, 8'h50};
	int fails = 0, testsRun = 0, cyc = 0, sinkCnt = 0, sinkBad = 0, o2dCnt = 0, rxPosBad = 0;

	always #2 clk = ~clk;
	// port data sources answer in the same cycle with a position-coded byte
	assign srcByte = {srcPort ^ srcField, srcIndex[4:0]};
	assign txByte = {txPort, txIndex[4:0]} ^ 8'h5A;

	dpp_link_if link();
	dpp_device_end dpp_device_end_i (.clk(clk), .rstn(rstn), .link(link), .portMap(pmap),
		.isInputOnly(isInputOnly), .cycleReq(cycleReq), .busy(busy), .dinStatus(dinStatus),
		.genDiag(genDiag), .sensorDiag(sensorDiag), .actDiag(actDiag), .iolDiag(iolDiag),
		.dinDiag(dinDiag), .srcField(srcField), .srcPort(srcPort), .srcIndex(srcIndex),
		.srcByte(srcByte), .temp_overrun_flag(devFlags[0]), .supply_undervolt_flag(devFlags[1]),
		.supply_overvolt_flag(devFlags[2]), .internal_fault_flag(devFlags[3]),
		.device_state_flag(devFlags[4]), .extStatus(extStatus), .outShortGnd(shortGnd),
		.outShortNoGnd(shortNoGnd), .outOverload(overload), .outDrive(outDrive),
		.outLedRed(outLedRed), .sinkValid(sinkValid), .sinkPort(sinkPort),
		.sinkIndex(sinkIndex), .sinkByte(sinkByte), .outLenErr(outLenErr));
	dpp_host_end dpp_host_end_i (.clk(clk), .rstn(rstn), .link(link), .portMap(pmap),
		.txStart(txStart), .txBusy(txBusy), .doutCtrl(doutCtrl), .txPort(txPort),
		.txIndex(txIndex), .txByte(txByte), .rxValid(rxValid), .rxKind(rxKind),
		.rxField(rxField), .rxPort(rxPort), .rxIndex(rxIndex), .rxByte(rxByte),
		.rxLenErr(rxLenErr));
	dpp_link_monitor dpp_link_monitor_i (.clk(clk), .rstn(rstn), .o2dValid(link.o2dValid),
		.o2dData(link.o2dData), .o2dLast(link.o2dLast), .d2hValid(link.d2hValid),
		.d2hData(link.d2hData), .d2hLast(link.d2hLast), .d2hKind(link.d2hKind));

	task automatic check(string what, logic [15:0] seen, logic [15:0] want);
		testsRun++;
		if (seen !== want) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic add(int f, int p, int n);
		for (int i = 0; i < n; i++) begin
			expImg.push_back({p[2:0] ^ f[2:0], i[4:0]});
		end
	endtask

	task automatic send_out(int nOut);
		int t;
		t = 0;
		sinkCnt = 0;
		sinkBad = 0;
		o2dCnt = 0;
		@(posedge clk);
		txStart <= 1'b1;
		@(posedge clk);
		txStart <= 1'b0;
		while ((link.o2dValid && link.o2dLast) !== 1'b1 && t < 2000) begin
			@(negedge clk);
			t++;
		end
		repeat (4) @(negedge clk);
		check("output image bytes", o2dCnt, nOut);
		check("port data bytes", sinkCnt, nOut - 4);
		check("port data content", sinkBad, 0);
		check("output length flag", outLenErr, 1'b0);
		check("tx busy after send", txBusy, 1'b0);
		$display("output image of %0d bytes finished", nOut);
	endtask

	task automatic run_frame(string name, int nImg);
		logic [111:0] hdr;
		logic [47:0] od;
		logic [143:0] de;
		logic [15:0] st;
		int t;
		expImg.delete();
		rxPosBad = 0;
		img.delete();
		dg.delete();
		rxImg.delete();
		@(posedge clk);
		cycleReq <= 1'b1;
		@(posedge clk);
		cycleReq <= 1'b0;
		t = 0;
		while ((link.d2hValid && link.d2hKind && link.d2hLast) !== 1'b1 && t < 2000) begin
			@(negedge clk);
			t++;
		end
		repeat (3) @(negedge clk);
		// mixed variant: channels 9-16 are not inputs, so that status byte reads zero
		st = isInputOnly ? dinStatus : {8'h00, dinStatus[7:0]};
		hdr = {iolDiag, actDiag, sensorDiag, genDiag, st};
		for (int k = 0; k < 14; k++) begin
			expImg.push_back(hdr[8*k +: 8]);
		end
		for (int p = 0; p < 8; p++) begin
			add(1, p, pmap.inSize[p] > 6'h20 ? 32 : pmap.inSize[p]);
			add(2, p, 2);
			add(3, p, pmap.ext[p] != DPP_X_NONE ? 8 : 0);
			add(4, p, pmap.ext[p] == DPP_X_EXT_EVT ? 12 : 0);
		end
		od = {4'h0, expOv, 8'h00, 4'h0, expTp, 8'h00, 4'h0, expRb, 8'h00};
		de = {extStatus != 8'h00, 7'h00, devFlags[4], 1'b0, extStatus[6],
			extStatus != 8'h00 && !extStatus[6], devFlags[3:0], isInputOnly ? 48'h0 : od,
			isInputOnly ? dinDiag : dinDiag & 64'h00FF00FF00FF00FF, st};
		check({name, " frame done"}, t < 2000, 1'b1);
		check({name, " image size"}, img.size(), nImg);
		check({name, " received size"}, rxImg.size(), nImg);
		for (int k = 0; k < nImg; k++) begin
			check($sformatf("%s image %0d", name, k), img[k], expImg[k]);
			check($sformatf("%s received %0d", name, k), rxImg[k], expImg[k]);
		end
		check({name, " diag size"}, dg.size(), 18);
		for (int k = 0; k < 18; k++) begin
			check($sformatf("%s diag %0d", name, k), dg[k], de[8*k +: 8]);
		end
		check({name, " input length flag"}, rxLenErr, 1'b0);
		check({name, " received positions"}, rxPosBad, 0);
		check({name, " busy after frame"}, busy, 1'b0);
		$display("%s finished", name);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (link.d2hValid === 1'b1) begin
			if (link.d2hKind) begin
				dg.push_back(link.d2hData);
			end else begin
				img.push_back(link.d2hData);
			end
		end
		if (rxValid && !rxKind) begin
			rxImg.push_back(rxByte);
			rxPosBad += rxField != DPP_F_HDR && ({rxPort ^ rxField, rxIndex[4:0]} !== rxByte);
		end
		if (link.o2dValid) begin
			o2dCnt++;
		end
		if (sinkValid) begin
			sinkCnt++;
			sinkBad += (({sinkPort, sinkIndex[4:0]} ^ 8'h5A) !== sinkByte);
		end
		// a hang costs at most this many cycles
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		check("busy after reset", busy, 1'b0);
		check("drive after reset", outDrive, 4'h0);
		send_out(260);
		check("drive on", outDrive, 4'hF);
		@(posedge clk);
		shortGnd <= 4'h1;
		shortNoGnd <= 4'h2;
		overload <= 4'h4;
		repeat (3) @(negedge clk);
		check("drive after fault", outDrive, 4'h8);
		check("red indicators", outLedRed, 4'h7);
		@(posedge clk);
		shortGnd <= 4'h0;
		shortNoGnd <= 4'h0;
		overload <= 4'h0;
		expRb = 4'h1;
		expTp = 4'h2;
		expOv = 4'h4;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			extStatus <= dpp_xstat_t'(codes[k]);
			devFlags <= 5'(k * 3);
			run_frame($sformatf("status %h", codes[k]), 446);
		end
		@(posedge clk);
		pmap <= {24'h0, 6'h02, 6'h04, 6'h00, 6'h02, 24'h0, 6'h08, 6'h10, 6'h20, 6'h02, 16'h0024};
		send_out(62);
		run_frame("resized map", 66);
		@(posedge clk);
		isInputOnly <= 1'b1;
		dinStatus <= 16'h5AA5;
		send_out(62);
		check("input-only drive", outDrive, 4'h0);
		run_frame("input-only", 66);
		wrap_up();
	end
endmodule

`default_nettype wire

/* verilog/dpp_cfg.svh */
// constants for the diagnostic and process image packer
`ifndef DPP_CFG_SVH
`define DPP_CFG_SVH

// ------------------------------------------------------------------
// image geometry
// ------------------------------------------------------------------
`define DPP_IN_HDR_LEN 6'h0E
`define DPP_OUT_HDR_LEN 6'h04
`define DPP_PORT_DATA_MAX 6'h20
`define DPP_PQI_LEN 6'h02
`define DPP_EXT_LEN 6'h08
`define DPP_EVT_LEN 6'h0C
`define DPP_LAST_PORT 3'h7
`define DPP_DEF_OUT_LEN 16'h0104
`define DPP_DEF_IN_LEN 16'h01BE
`define DPP_STEP_LIMIT 34

// ------------------------------------------------------------------
// diagnostic frame
// ------------------------------------------------------------------
`define DPP_DIAG_LAST_IDX 5'h11
`define DPP_DIN_DIAG_MIXED_MASK 64'h00FF00FF00FF00FF
`define DPP_OUT_CTRL_IDX 6'h01

// ------------------------------------------------------------------
// extended status codes
// ------------------------------------------------------------------
`define DPP_XS_ALARM_BIT 6
`define DPP_XS_NO_ERROR 8'h00
`define DPP_XS_WARN_IO_CFG_INVALID 8'h05
`define DPP_XS_WARN_DPRAM_NO_SLOT 8'h06
`define DPP_XS_WARN_DPRAM_GENERIC 8'h0F
`define DPP_XS_WARN_SEND_SYS_INFO 8'h12
`define DPP_XS_ALARM_ATTR_INIT_CRC 8'h41
`define DPP_XS_ALARM_CFG_INIT_CRC 8'h42
`define DPP_XS_ALARM_CFG_LENGTH 8'h4B
`define DPP_XS_ALARM_READ_NVM 8'h4C
`define DPP_XS_ALARM_ATTR_READBACK 8'h4D
`define DPP_XS_ALARM_CFG_READBACK 8'h4E
`define DPP_XS_ALARM_CFG_ATTR_READ 8'h50

`endif

/* verilog/dpp_device_end.sv */
// device end: builds the input image and diagnostic frame, consumes the output image
// Behaviour
// - mixed variant: output flags only channels 9-12
// - input-only variant: output diagnostics all reserved
// - short or overload forces output inactive
// - output channel error lights red LED
// - readback flag: short, actuator to ground
// - test-pulse flag: short, actuator not grounded
// - overload flag on output overload
// - device diagnostic bits and extended flag
// - extended code: warnings have bit6 clear
// - alarm codes have bit6 set
// - default images are 260 and 446 bytes
// - output image: control, reserved, eight ports
// - input header: status, diagnostics, link block
// - per port: data, qualifier, extended, events
// - default port areas at maximum size
// - port sizing recomputes all following offsets
// - diagnostic frame is fixed 18 bytes
`timescale 1ns/1ps
`default_nettype none
`include "dpp_cfg.svh"

module dpp_device_end
	import dpp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link
	dpp_link_if.dev link,
	// configuration
	input wire dpp_map_t portMap,
	input wire logic isInputOnly,
	// frame start
	input wire logic cycleReq,
	output logic busy,
	// fixed input header sources
	input wire logic [15:0] dinStatus,
	input wire logic [15:0] genDiag,
	input wire logic [15:0] sensorDiag,
	input wire logic [15:0] actDiag,
	input wire logic [47:0] iolDiag,
	input wire logic [63:0] dinDiag,
	// port byte fetch, answered in the same cycle
	output dpp_field_t srcField,
	output logic [2:0] srcPort,
	output logic [5:0] srcIndex,
	input wire logic [7:0] srcByte,
	// device condition
	input wire logic temp_overrun_flag,
	input wire logic supply_undervolt_flag,
	input wire logic supply_overvolt_flag,
	input wire logic internal_fault_flag,
	input wire logic device_state_flag,
	input wire dpp_xstat_t extStatus,
	// safety outputs, channels 9 to 12
	input wire logic [3:0] outShortGnd,
	input wire logic [3:0] outShortNoGnd,
	input wire logic [3:0] outOverload,
	output logic [3:0] outDrive,
	output logic [3:0] outLedRed,
	// output image sink
	output logic sinkValid,
	output logic [2:0] sinkPort,
	output logic [5:0] sinkIndex,
	output logic [7:0] sinkByte,
	output logic outLenErr
);

	typedef enum logic [1:0] {
		DPP_PH_IDLE = 2'h0,
		DPP_PH_IMG = 2'h1,
		DPP_PH_DIAG = 2'h2
	} dpp_phase_t;

	typedef struct packed {
		dpp_phase_t phase;
		dpp_pos_t txPos;
		logic [4:0] diagIdx;
		logic [143:0] diagSnap;
		logic txValid;
		logic [7:0] txData;
		logic txLast;
		logic txKind;
		dpp_pos_t rxPos;
		logic rxOvf;
		logic [3:0] ctrl;
		logic sValid;
		logic [2:0] sPort;
		logic [5:0] sIndex;
		logic [7:0] sByte;
		logic lenErr;
	} dpp_dev_t;

	localparam dpp_dev_t DPP_DEV_RESET = '{
		phase: DPP_PH_IDLE,
		txPos: DPP_POS_START,
		diagIdx: 5'h00,
		diagSnap: 144'h0,
		txValid: 1'b0,
		txData: 8'h00,
		txLast: 1'b0,
		txKind: 1'b0,
		rxPos: DPP_POS_START,
		rxOvf: 1'b0,
		ctrl: 4'h0,
		sValid: 1'b0,
		sPort: 3'h0,
		sIndex: 6'h00,
		sByte: 8'h00,
		lenErr: 1'b0
	};

	dpp_dev_t s_q, s_d;

	// ------------------------------------------------------------------
	// output protection
	// ------------------------------------------------------------------
	logic [3:0] flagRb, flagTp, flagOv;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gGuard
			dpp_out_guard uGuard (
				.clk(clk),
				.rstn(rstn),
				.enable(~isInputOnly),
				.cmd(s_q.ctrl[g]),
				.shortGnd(outShortGnd[g]),
				.shortNoGnd(outShortNoGnd[g]),
				.overload(outOverload[g]),
				.drive(outDrive[g]),
				.ledRed(outLedRed[g]),
				.flagReadback(flagRb[g]),
				.flagTestPulse(flagTp[g]),
				.flagOverload(flagOv[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// image contents
	// ------------------------------------------------------------------
	logic [15:0] statusImg;
	logic [63:0] dinDiagImg;
	logic [47:0] doutDiagImg;
	logic [15:0] devDiagImg;
	logic [111:0] inHdr;
	logic [143:0] diagFrame;
	logic xsWarn, xsAlarm, xsPresent;
	always_comb begin
		// channels 9-16 of the mixed variant are not inputs
		statusImg = isInputOnly ? dinStatus : {8'h00, dinStatus[7:0]};
		dinDiagImg = isInputOnly ? dinDiag : (dinDiag & `DPP_DIN_DIAG_MIXED_MASK);
		if (isInputOnly) begin
			doutDiagImg = 48'h0;
		end else begin
			doutDiagImg = {4'h0, flagOv, 8'h00, 4'h0, flagTp, 8'h00, 4'h0, flagRb, 8'h00};
		end
		xsPresent = extStatus != DPP_XS_NONE;
		xsAlarm = extStatus[`DPP_XS_ALARM_BIT];
		xsWarn = xsPresent & ~extStatus[`DPP_XS_ALARM_BIT];
		devDiagImg = {xsPresent, 7'h00, device_state_flag, 1'b0, xsAlarm, xsWarn,
			internal_fault_flag, supply_overvolt_flag, supply_undervolt_flag,
			temp_overrun_flag};
		inHdr = {iolDiag, actDiag, sensorDiag, genDiag, statusImg};
		diagFrame = {devDiagImg, doutDiagImg, dinDiagImg, statusImg};
	end

	assign srcField = s_q.txPos.field;
	assign srcPort = s_q.txPos.port;
	assign srcIndex = s_q.txPos.idx;

	// ------------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------------
	dpp_pos_t txNext, rxNext;
	always_comb begin
		txNext = dpp_step(s_q.txPos, portMap, 1'b1);
		rxNext = dpp_step(s_q.rxPos, portMap, 1'b0);
		s_d = s_q;
		s_d.txValid = 1'b0;
		s_d.txLast = 1'b0;
		s_d.sValid = 1'b0;
		case (s_q.phase)
			DPP_PH_IDLE: begin
				if (cycleReq) begin
					s_d.phase = DPP_PH_IMG;
					s_d.txPos = DPP_POS_START;
				end
			end
			DPP_PH_IMG: begin
				s_d.txValid = 1'b1;
				s_d.txKind = 1'b0;
				if (s_q.txPos.field == DPP_F_HDR) begin
					s_d.txData = inHdr[{s_q.txPos.idx[3:0], 3'h0} +: 8];
				end else begin
					s_d.txData = srcByte;
				end
				s_d.txPos = txNext;
				if (txNext.field == DPP_F_DONE) begin
					// the diagnostic frame is taken as one snapshot so it stays coherent
					s_d.txLast = 1'b1;
					s_d.phase = DPP_PH_DIAG;
					s_d.diagIdx = 5'h00;
					s_d.diagSnap = diagFrame;
				end
			end
			DPP_PH_DIAG: begin
				s_d.txValid = 1'b1;
				s_d.txKind = 1'b1;
				s_d.txData = s_q.diagSnap[{s_q.diagIdx, 3'h0} +: 8];
				s_d.diagIdx = s_q.diagIdx + 5'h01;
				if (s_q.diagIdx == `DPP_DIAG_LAST_IDX) begin
					s_d.txLast = 1'b1;
					s_d.phase = DPP_PH_IDLE;
				end
			end
			default: begin
				s_d.phase = DPP_PH_IDLE;
			end
		endcase
		// output image receive
		if (link.o2dValid) begin
			if (s_q.rxPos.field == DPP_F_DONE) begin
				s_d.rxOvf = 1'b1;
			end else if (s_q.rxPos.field == DPP_F_HDR) begin
				// only the low nibble of the control word's upper byte is a channel
				if (s_q.rxPos.idx == `DPP_OUT_CTRL_IDX) begin
					s_d.ctrl = link.o2dData[3:0];
				end
			end else begin
				s_d.sValid = 1'b1;
				s_d.sPort = s_q.rxPos.port;
				s_d.sIndex = s_q.rxPos.idx;
				s_d.sByte = link.o2dData;
			end
			s_d.rxPos = rxNext;
			if (link.o2dLast) begin
				s_d.lenErr = s_q.rxOvf | (s_q.rxPos.field == DPP_F_DONE) |
					(rxNext.field != DPP_F_DONE);
				s_d.rxOvf = 1'b0;
				s_d.rxPos = DPP_POS_START;
			end
		end
		if (isInputOnly) begin
			s_d.ctrl = 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= DPP_DEV_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.phase != DPP_PH_IDLE;
	assign link.d2hValid = s_q.txValid;
	assign link.d2hData = s_q.txData;
	assign link.d2hLast = s_q.txLast;
	assign link.d2hKind = s_q.txKind;
	assign sinkValid = s_q.sValid;
	assign sinkPort = s_q.sPort;
	assign sinkIndex = s_q.sIndex;
	assign sinkByte = s_q.sByte;
	assign outLenErr = s_q.lenErr;

endmodule

`default_nettype wire

/* verilog/dpp_host_end.sv */
// controller end: sends the output image, splits received images into fields
`timescale 1ns/1ps
`default_nettype none
`include "dpp_cfg.svh"

module dpp_host_end
	import dpp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link
	dpp_link_if.host link,
	// configuration, must match the device
	input wire dpp_map_t portMap,
	// output image send
	input wire logic txStart,
	output logic txBusy,
	input wire logic [15:0] doutCtrl,
	output logic [2:0] txPort,
	output logic [5:0] txIndex,
	input wire logic [7:0] txByte,
	// received bytes
	output logic rxValid,
	output logic rxKind,
	output dpp_field_t rxField,
	output logic [2:0] rxPort,
	output logic [5:0] rxIndex,
	output logic [7:0] rxByte,
	output logic rxLenErr
);

	typedef struct packed {
		logic sending;
		dpp_pos_t txPos;
		logic oValid;
		logic [7:0] oData;
		logic oLast;
		dpp_pos_t rxPos;
		logic [4:0] diagIdx;
		logic rValid;
		logic rKind;
		dpp_field_t rField;
		logic [2:0] rPort;
		logic [5:0] rIndex;
		logic [7:0] rByte;
		logic err;
	} dpp_host_t;

	dpp_host_t s_q, s_d;
	dpp_pos_t txNext, rxNext;
	logic [31:0] outHdr;

	always_comb begin
		outHdr = {16'h0000, doutCtrl};
		txNext = dpp_step(s_q.txPos, portMap, 1'b0);
		rxNext = dpp_step(s_q.rxPos, portMap, 1'b1);
		s_d = s_q;
		s_d.oValid = 1'b0;
		s_d.oLast = 1'b0;
		s_d.rValid = 1'b0;
		if (!s_q.sending) begin
			if (txStart) begin
				s_d.sending = 1'b1;
				s_d.txPos = DPP_POS_START;
			end
		end else begin
			s_d.oValid = 1'b1;
			if (s_q.txPos.field == DPP_F_HDR) begin
				s_d.oData = outHdr[{s_q.txPos.idx[1:0], 3'h0} +: 8];
			end else begin
				s_d.oData = txByte;
			end
			s_d.txPos = txNext;
			if (txNext.field == DPP_F_DONE) begin
				s_d.oLast = 1'b1;
				s_d.sending = 1'b0;
			end
		end
		if (link.d2hValid) begin
			s_d.rValid = 1'b1;
			s_d.rKind = link.d2hKind;
			s_d.rByte = link.d2hData;
			if (link.d2hKind) begin
				// diagnostic frame bytes report as header field, index 0 to 17
				s_d.rField = DPP_F_HDR;
				s_d.rPort = 3'h0;
				s_d.rIndex = {1'b0, s_q.diagIdx};
				s_d.diagIdx = s_q.diagIdx + 5'h01;
				if (link.d2hLast) begin
					s_d.err = s_q.diagIdx != `DPP_DIAG_LAST_IDX;
					s_d.diagIdx = 5'h00;
				end
			end else begin
				s_d.rField = s_q.rxPos.field;
				s_d.rPort = s_q.rxPos.port;
				s_d.rIndex = s_q.rxPos.idx;
				s_d.rxPos = rxNext;
				if (link.d2hLast) begin
					s_d.err = (s_q.rxPos.field == DPP_F_DONE) | (rxNext.field != DPP_F_DONE);
					s_d.rxPos = DPP_POS_START;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '{sending: 1'b0, txPos: DPP_POS_START, oValid: 1'b0, oData: 8'h00,
				oLast: 1'b0, rxPos: DPP_POS_START, diagIdx: 5'h00, rValid: 1'b0,
				rKind: 1'b0, rField: DPP_F_HDR, rPort: 3'h0, rIndex: 6'h00,
				rByte: 8'h00, err: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign txBusy = s_q.sending;
	assign txPort = s_q.txPos.port;
	assign txIndex = s_q.txPos.idx;
	assign link.o2dValid = s_q.oValid;
	assign link.o2dData = s_q.oData;
	assign link.o2dLast = s_q.oLast;
	assign rxValid = s_q.rValid;
	assign rxKind = s_q.rKind;
	assign rxField = s_q.rField;
	assign rxPort = s_q.rPort;
	assign rxIndex = s_q.rIndex;
	assign rxByte = s_q.rByte;
	assign rxLenErr = s_q.err;

endmodule

`default_nettype wire

/* verilog/dpp_link_if.sv */
// byte link between the device end and the network controller end
`timescale 1ns/1ps
`default_nettype none

interface dpp_link_if;
	// output image, controller to device
	logic o2dValid;
	logic [7:0] o2dData;
	logic o2dLast;
	// input image (kind 0) and diagnostic frame (kind 1), device to controller
	logic d2hValid;
	logic [7:0] d2hData;
	logic d2hLast;
	logic d2hKind;

	modport dev (
		input o2dValid,
		input o2dData,
		input o2dLast,
		output d2hValid,
		output d2hData,
		output d2hLast,
		output d2hKind
	);

	modport host (
		output o2dValid,
		output o2dData,
		output o2dLast,
		input d2hValid,
		input d2hData,
		input d2hLast,
		input d2hKind
	);
endinterface

`default_nettype wire

/* verilog/dpp_out_guard.sv */
// one protected safety output: fault detection, shut-off and red indicator
`timescale 1ns/1ps
`default_nettype none

module dpp_out_guard
	import dpp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic enable,
	input wire logic cmd,
	// fault detection
	input wire logic shortGnd,
	input wire logic shortNoGnd,
	input wire logic overload,
	// results
	output logic drive,
	output logic ledRed,
	output logic flagReadback,
	output logic flagTestPulse,
	output logic flagOverload
);

	typedef struct packed {
		logic rb;
		logic tp;
		logic ov;
		logic drv;
	} dpp_guard_t;

	dpp_guard_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		// a fault holds until the command is withdrawn; new detection wins
		s_d.rb = enable & (shortGnd | (s_q.rb & cmd));
		s_d.tp = enable & (shortNoGnd | (s_q.tp & cmd));
		s_d.ov = enable & (overload | (s_q.ov & cmd));
		s_d.drv = enable & cmd & ~(s_d.rb | s_d.tp | s_d.ov);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign drive = s_q.drv;
	assign ledRed = s_q.rb | s_q.tp | s_q.ov;
	assign flagReadback = s_q.rb;
	assign flagTestPulse = s_q.tp;
	assign flagOverload = s_q.ov;

endmodule

`default_nettype wire

/* verilog/dpp_pkg.sv */
// types and field walk shared by both ends of the image link
`default_nettype none
`include "dpp_cfg.svh"

package dpp_pkg;

	typedef enum logic [2:0] {
		DPP_F_HDR = 3'h0,
		DPP_F_DATA = 3'h1,
		DPP_F_PQI = 3'h2,
		DPP_F_EXT = 3'h3,
		DPP_F_EVT = 3'h4,
		DPP_F_DONE = 3'h5
	} dpp_field_t;

	typedef enum logic [1:0] {
		DPP_X_NONE = 2'h0,
		DPP_X_EXT = 2'h1,
		DPP_X_EXT_EVT = 2'h2
	} dpp_ext_t;

	typedef enum logic [7:0] {
		DPP_XS_NONE = `DPP_XS_NO_ERROR,
		DPP_XS_W_CFG = `DPP_XS_WARN_IO_CFG_INVALID,
		DPP_XS_W_SLOT = `DPP_XS_WARN_DPRAM_NO_SLOT,
		DPP_XS_W_DPRAM = `DPP_XS_WARN_DPRAM_GENERIC,
		DPP_XS_W_SYSINFO = `DPP_XS_WARN_SEND_SYS_INFO,
		DPP_XS_A_ATTR_CRC = `DPP_XS_ALARM_ATTR_INIT_CRC,
		DPP_XS_A_CFG_CRC = `DPP_XS_ALARM_CFG_INIT_CRC,
		DPP_XS_A_CFG_LEN = `DPP_XS_ALARM_CFG_LENGTH,
		DPP_XS_A_READ = `DPP_XS_ALARM_READ_NVM,
		DPP_XS_A_ATTR_RB = `DPP_XS_ALARM_ATTR_READBACK,
		DPP_XS_A_CFG_RB = `DPP_XS_ALARM_CFG_READBACK,
		DPP_XS_A_CFG_ATTR = `DPP_XS_ALARM_CFG_ATTR_READ
	} dpp_xstat_t;

	typedef struct packed {
		dpp_field_t field;
		logic [2:0] port;
		logic [5:0] idx;
	} dpp_pos_t;

	typedef struct packed {
		logic [7:0][5:0] inSize;
		logic [7:0][5:0] outSize;
		dpp_ext_t [7:0] ext;
	} dpp_map_t;

	localparam dpp_pos_t DPP_POS_START = '{field: DPP_F_HDR, port: 3'h0, idx: 6'h00};

	// ------------------------------------------------------------------
	// field lengths; oversize requests are clamped to the port maximum
	// ------------------------------------------------------------------
	function automatic logic [5:0] dpp_field_len(dpp_pos_t p, dpp_map_t m, logic dirIn);
		logic [5:0] sz;
		sz = dirIn ? m.inSize[p.port] : m.outSize[p.port];
		if (sz > `DPP_PORT_DATA_MAX) begin
			sz = `DPP_PORT_DATA_MAX;
		end
		case (p.field)
			DPP_F_HDR: return dirIn ? `DPP_IN_HDR_LEN : `DPP_OUT_HDR_LEN;
			DPP_F_DATA: return sz;
			DPP_F_PQI: return dirIn ? `DPP_PQI_LEN : 6'h00;
			DPP_F_EXT: return (dirIn && m.ext[p.port] != DPP_X_NONE) ? `DPP_EXT_LEN : 6'h00;
			DPP_F_EVT: return (dirIn && m.ext[p.port] == DPP_X_EXT_EVT) ? `DPP_EVT_LEN : 6'h00;
			default: return 6'h00;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// next byte position; empty fields are skipped so offsets follow the map
	// ------------------------------------------------------------------
	function automatic dpp_pos_t dpp_step(dpp_pos_t pos, dpp_map_t m, logic dirIn);
		dpp_pos_t n;
		logic found;
		n = pos;
		found = 1'b0;
		if (pos.field != DPP_F_DONE && (pos.idx + 6'h01) < dpp_field_len(pos, m, dirIn)) begin
			n.idx = pos.idx + 6'h01;
			found = 1'b1;
		end
		for (int k = 0; k < `DPP_STEP_LIMIT; k++) begin
			if (!found && n.field != DPP_F_DONE) begin
				n.idx = 6'h00;
				case (n.field)
					DPP_F_HDR: begin
						n.field = DPP_F_DATA;
						n.port = 3'h0;
					end
					DPP_F_EVT: begin
						if (n.port == `DPP_LAST_PORT) begin
							n.field = DPP_F_DONE;
						end else begin
							n.field = DPP_F_DATA;
							n.port = n.port + 3'h1;
						end
					end
					DPP_F_DATA: n.field = DPP_F_PQI;
					DPP_F_PQI: n.field = DPP_F_EXT;
					DPP_F_EXT: n.field = DPP_F_EVT;
					default: n.field = DPP_F_DONE;
				endcase
				if (n.field == DPP_F_DONE || dpp_field_len(n, m, dirIn) != 6'h00) begin
					found = 1'b1;
				end
			end
		end
		return n;
	endfunction

endpackage

`default_nettype wire
